// ### rbf_regs.svh
// Constants for the receive bit FIFO
`ifndef RBF_REGS_SVH
`define RBF_REGS_SVH
`define RBF_DEPTH 256
`define RBF_PTR_W 8
`define RBF_PTR_MAX 8'hff
`define RBF_CNT_W 9
`define RBF_WORD_BITS 32
`define RBF_WORD_BITS_C 6'h20
`define RBF_STAT_BITS 8
`define RBF_STAT_OVF_POS 7
`define RBF_STAT_UNDEF_POS 6
`define RBF_STAT_CNT_W 6
`endif

// ### rbf_pkg.sv
// Types for the receive bit FIFO
package rbf_pkg;
  typedef enum logic [2:0] {
    RBF_IDLE = 3'b001,
    RBF_DATA = 3'b010,
    RBF_STAT = 3'b100
  } rbf_rd_state_t;
endpackage

// ### rbf_receive_bit_fifo.sv
// Receive bit FIFO: 256-bit store, lock, init and SPI read with status word
// Functional notes
// - FIFO is written with frame data only in packet FIFO mode.
// - Storage holds at most 256 payload bits.
// - Extended 8-bit start pattern mode inserts one leading pattern-select bit.
// - Bit-addressable store with independent write and read ports.
// - Writing begins at frame start pattern detection.
// - Write pointer advances once per data clock pulse.
// - Read pointer advances once per bit read by the SPI side.
// - Both pointers wrap from 255 to zero.
// - Writing stops at end of message or sync loss.
// - With lock enabled, end of message locks the FIFO.
// - While locked, no further data accepted; first packet preserved.
// - With lock enabled, receive chain is frozen until unlock.
// - Unlock on full readout, lock enable cleared, or cycle-start init event.
// - Each read ends with status word; bits 0..5 count valid bits, bit 6 undefined.
// - Write pointer overtaking read pointer sets overflow flag at status bit 7.
// - While overflow set, data bits and valid count are undefined.
// - First frame start after overflow clears the flag and initializes FIFO.
// - Init-at-cycle-start initializes FIFO on host run or polling-to-run.
// - Init-at-frame-start initializes FIFO on frame start when not locked.
// - FIFO data leaves earliest received bit first.
`include "rbf_regs.svh"
module rbf_receive_bit_fifo
  import rbf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic packet_fifo_mode,
  input wire logic lock_enable_bit,
  input wire logic init_at_cycle_start,
  input wire logic init_at_frame_start,
  input wire logic ext_start_mode,
  input wire logic frame_start_pattern,
  input wire logic pattern_b_matched,
  input wire logic end_of_message,
  input wire logic sync_lost,
  input wire logic enter_host_run,
  input wire logic poll_to_run,
  input wire logic data_clk,
  input wire logic data_bit,
  input wire logic rd_start,
  input wire logic rd_bit_ready,
  output logic rd_bit_valid,
  output logic rd_bit,
  output logic rd_is_status,
  output logic rd_last,
  output logic locked,
  output logic rx_chain_freeze,
  output logic overflow_flag,
  output logic writing
);

  // Whole module state
  typedef struct packed {
    logic [`RBF_DEPTH-1:0] mem;
    logic [`RBF_PTR_W-1:0] wptr;
    logic [`RBF_PTR_W-1:0] rptr;
    logic [`RBF_CNT_W-1:0] fill;
    logic wr_active;
    logic lock;
    logic ovf;
    rbf_rd_state_t rst_state;
    logic [5:0] bit_idx;
    logic [5:0] valid_cnt;
    logic [`RBF_STAT_BITS-1:0] stat;
    logic [1:0] buf_v;
    logic [1:0] buf_d;
    logic [1:0] buf_s;
    logic [1:0] buf_l;
    logic out_v;
    logic out_d;
    logic out_s;
    logic out_l;
  } rbf_state_t;

  rbf_state_t st_reg;
  rbf_state_t st_next;

  logic cyc_init;
  logic fs_init;
  logic do_init;
  logic wr_take;
  logic lead_take;
  logic wr_bit;
  logic [`RBF_PTR_W-1:0] wr_addr;
  logic rd_take;
  logic push;
  logic push_d;
  logic push_s;
  logic push_l;
  logic buf_ready;
  logic pop;
  logic unlock;
  logic [`RBF_DEPTH-1:0] wr_sel;

  // Init triggers; overflow recovery and frame-start init are one event
  assign cyc_init = init_at_cycle_start && (enter_host_run || poll_to_run);
  assign fs_init = frame_start_pattern && packet_fifo_mode &&
                   ((init_at_frame_start && !st_reg.lock) || st_reg.ovf);
  assign do_init = cyc_init || fs_init;

  // Write strobe; the extended-mode pattern bit goes in at the start edge itself,
  // and a data bit clocked on that same edge is dropped in its favour
  assign lead_take = frame_start_pattern && packet_fifo_mode && ext_start_mode &&
                     !st_reg.lock;
  assign wr_take = data_clk && st_reg.wr_active && !st_reg.lock && !lead_take;
  assign wr_bit = lead_take ? pattern_b_matched : data_bit;
  assign wr_addr = do_init ? '0 : st_reg.wptr;

  // Two-entry skid buffer; only slot 0 feeds the output register
  assign buf_ready = !st_reg.buf_v[1];
  assign pop = st_reg.buf_v[0] && (!st_reg.out_v || rd_bit_ready);
  assign rd_take = (st_reg.rst_state == RBF_DATA) && buf_ready &&
                   (st_reg.fill != '0) && (st_reg.bit_idx != `RBF_WORD_BITS_C);
  assign push = buf_ready && ((st_reg.rst_state == RBF_DATA && (rd_take ||
                st_reg.fill == '0 || st_reg.bit_idx == `RBF_WORD_BITS_C)) ||
                st_reg.rst_state == RBF_STAT);
  assign push_s = (st_reg.rst_state == RBF_STAT);
  assign push_d = push_s ? st_reg.stat[`RBF_STAT_BITS-1 - st_reg.bit_idx[2:0]]
                         : st_reg.mem[st_reg.rptr];
  assign push_l = push_s && (st_reg.bit_idx[2:0] == 3'h7);

  // Lock release when the last bit leaves, lock disabled, or cycle init
  assign unlock = !lock_enable_bit || cyc_init ||
                  (rd_take && st_reg.fill == 9'h001);

  // Per-bit write decode of the two-port store
  genvar gi;
  generate
    for (gi = 0; gi < `RBF_DEPTH; gi++) begin : g_wsel
      assign wr_sel[gi] = (wr_take || lead_take) && (wr_addr == 8'(gi));
    end
  endgenerate

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    // Write port
    for (int i = 0; i < `RBF_DEPTH; i++) begin
      if (wr_sel[i]) begin
        st_next.mem[i] = wr_bit;
      end
    end
    if (wr_take) begin
      st_next.wptr = st_reg.wptr + 8'h01;
    end
    // Read port
    if (rd_take) begin
      st_next.rptr = st_reg.rptr + 8'h01;
      st_next.valid_cnt = st_reg.valid_cnt + 6'h01;
    end
    // Fill level; a write into a full store is the overtaking case
    if (wr_take && !rd_take) begin
      if (st_reg.fill == 9'h100) begin
        st_next.ovf = 1'b1;
      end else begin
        st_next.fill = st_reg.fill + 9'h001;
      end
    end else if (rd_take && !wr_take) begin
      st_next.fill = st_reg.fill - 9'h001;
    end
    // Frame control
    if (frame_start_pattern && packet_fifo_mode && !st_reg.lock) begin
      st_next.wr_active = 1'b1;
    end
    if (end_of_message || sync_lost || !packet_fifo_mode) begin
      st_next.wr_active = 1'b0;
    end
    if (end_of_message && lock_enable_bit && st_reg.wr_active) begin
      st_next.lock = 1'b1;
    end else if (st_reg.lock && unlock) begin
      st_next.lock = 1'b0;
    end
    // Whole-FIFO init; pointers, level and overflow flag only, data content is stale
    if (do_init) begin
      st_next.wptr = '0;
      st_next.rptr = '0;
      st_next.fill = '0;
      st_next.ovf = 1'b0;
    end
    // Pattern bit lands after any init of the same edge, so it leads the frame
    if (lead_take) begin
      st_next.wptr = wr_addr + 8'h01;
      if (st_next.fill == 9'h100) begin
        st_next.ovf = 1'b1;
      end else begin
        st_next.fill = st_next.fill + 9'h001;
      end
    end
    // Read sequencer: up to 32 data bits then 8 status bits
    unique case (st_reg.rst_state)
      RBF_IDLE: begin
        if (rd_start) begin
          st_next.rst_state = RBF_DATA;
          st_next.bit_idx = '0;
          st_next.valid_cnt = '0;
        end
      end
      RBF_DATA: begin
        if (rd_take) begin
          st_next.bit_idx = st_reg.bit_idx + 6'h01;
        end else if (buf_ready) begin
          st_next.rst_state = RBF_STAT;
          st_next.bit_idx = '0;
          st_next.stat = {st_reg.ovf, 1'b0, st_reg.valid_cnt};
        end
      end
      RBF_STAT: begin
        if (buf_ready) begin
          st_next.bit_idx = st_reg.bit_idx + 6'h01;
          if (st_reg.bit_idx[2:0] == 3'h7) begin
            st_next.rst_state = RBF_IDLE;
          end
        end
      end
      default: begin
        st_next.rst_state = RBF_IDLE;
      end
    endcase
    // Skid buffer: the ended-data push carries no bit, so skip it
    if (push && !(st_reg.rst_state == RBF_DATA && !rd_take)) begin
      if (pop) begin
        if (st_reg.buf_v[1]) begin
          st_next.buf_d[0] = st_reg.buf_d[1];
          st_next.buf_s[0] = st_reg.buf_s[1];
          st_next.buf_l[0] = st_reg.buf_l[1];
          st_next.buf_d[1] = push_d;
          st_next.buf_s[1] = push_s;
          st_next.buf_l[1] = push_l;
        end else begin
          st_next.buf_d[0] = push_d;
          st_next.buf_s[0] = push_s;
          st_next.buf_l[0] = push_l;
        end
      end else if (st_reg.buf_v[0]) begin
        st_next.buf_v[1] = 1'b1;
        st_next.buf_d[1] = push_d;
        st_next.buf_s[1] = push_s;
        st_next.buf_l[1] = push_l;
      end else begin
        st_next.buf_v[0] = 1'b1;
        st_next.buf_d[0] = push_d;
        st_next.buf_s[0] = push_s;
        st_next.buf_l[0] = push_l;
      end
    end else if (pop) begin
      st_next.buf_v = {1'b0, st_reg.buf_v[1]};
      st_next.buf_d[0] = st_reg.buf_d[1];
      st_next.buf_s[0] = st_reg.buf_s[1];
      st_next.buf_l[0] = st_reg.buf_l[1];
    end
    // Output register
    if (pop) begin
      st_next.out_v = 1'b1;
      st_next.out_d = st_reg.buf_d[0];
      st_next.out_s = st_reg.buf_s[0];
      st_next.out_l = st_reg.buf_l[0];
    end else if (rd_bit_ready) begin
      st_next.out_v = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{rst_state: RBF_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_bit_valid = st_reg.out_v;
  assign rd_bit = st_reg.out_d;
  assign rd_is_status = st_reg.out_s;
  assign rd_last = st_reg.out_l;
  assign locked = st_reg.lock;
  assign rx_chain_freeze = st_reg.lock;
  assign overflow_flag = st_reg.ovf;
  assign writing = st_reg.wr_active;

  // Checks
  AST_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_take && !do_init && st_reg.wptr == `RBF_PTR_MAX) |=> st_reg.wptr == 8'h00)
    else $error("write pointer did not wrap");
  AST_WPTR: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_take && !do_init) |=> st_reg.wptr == $past(st_reg.wptr) + 8'h01)
    else $error("write pointer did not advance");
  AST_LOCK: assert property (@(posedge ref_clk) disable iff (rst)
    (end_of_message && lock_enable_bit && writing) |=> locked)
    else $error("no lock at end of message");
  AST_NOWR: assert property (@(posedge ref_clk) disable iff (rst)
    (locked && !do_init) |=> st_reg.wptr == $past(st_reg.wptr))
    else $error("write while locked");
  AST_UNLK: assert property (@(posedge ref_clk) disable iff (rst)
    (locked && !lock_enable_bit && !end_of_message) |=> !locked)
    else $error("lock not released");
  AST_OVF: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_take && !rd_take && st_reg.fill == 9'h100 && !do_init) |=> overflow_flag)
    else $error("overflow not flagged");
  AST_OCLR: assert property (@(posedge ref_clk) disable iff (rst)
    (overflow_flag && frame_start_pattern && packet_fifo_mode) |=> !overflow_flag)
    else $error("overflow not cleared");
  AST_STOP: assert property (@(posedge ref_clk) disable iff (rst)
    (end_of_message || sync_lost) |=> !writing)
    else $error("writing did not stop");
  AST_CAP: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.fill <= 9'h100)
    else $error("fill above capacity");
  AST_ICYC: assert property (@(posedge ref_clk) disable iff (rst)
    cyc_init |=> (st_reg.fill == 9'h000 && st_reg.wptr == 8'h00))
    else $error("cycle init missed");
  AST_WORD: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.bit_idx <= `RBF_WORD_BITS_C)
    else $error("more than 32 data bits");
  COV_LOCK: cover property (@(posedge ref_clk) disable iff (rst) $rose(locked));
  COV_OVF: cover property (@(posedge ref_clk) disable iff (rst) $rose(overflow_flag));
  COV_STAT: cover property (@(posedge ref_clk) disable iff (rst) rd_bit_valid && rd_last);
  COV_STALL: cover property (@(posedge ref_clk) disable iff (rst) st_reg.buf_v == 2'b11);

endmodule

// ### rbf_reader.sv
// Controller model that drains FIFO bits and the status word
module rbf_reader (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic rd_start,
  input wire logic rd_bit_valid,
  input wire logic rd_bit,
  input wire logic rd_is_status,
  input wire logic rd_last,
  output logic rd_bit_ready,
  output logic [31:0] data,
  output logic [5:0] ndata,
  output logic [7:0] stat,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase = 2'h0;
  // Slow mode takes one bit in three, so the design must hold its bit
  always @(negedge ref_clk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
  end
  assign rd_bit_ready = !slow || (phase == 2'h0);
  // Data lands in arrival order; status shifts in from its top bit
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data <= 32'h0;
      ndata <= 6'h0;
      stat <= 8'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (rd_start) ndata <= 6'h0;
      else if (rd_bit_valid && rd_bit_ready && rd_is_status) begin
        stat <= {stat[6:0], rd_bit};
        done <= rd_last;
      end else if (rd_bit_valid && rd_bit_ready) begin
        data[ndata[4:0]] <= rd_bit;
        ndata <= ndata + 6'h1;
      end
    end
  end
endmodule

// ### tb_rbf_receive_bit_fifo.sv
// Self-checking bench for the receive bit FIFO
module tb_rbf_receive_bit_fifo;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, packet_fifo_mode, lock_enable_bit, init_at_cycle_start;
  logic init_at_frame_start, ext_start_mode, frame_start_pattern, pattern_b_matched;
  logic end_of_message, sync_lost, enter_host_run, poll_to_run, data_clk, data_bit;
  logic rd_start, rd_bit_ready, rd_bit_valid, rd_bit, rd_is_status, rd_last;
  logic locked, rx_chain_freeze, overflow_flag, writing, slow, done, lk, ovf;
  logic [31:0] data, rnd;
  logic [5:0] ndata;
  logic [7:0] stat;
  logic q[$];
  int n_fail = 0;
  int checks = 0;
  rbf_receive_bit_fifo uut (.*);
  rbf_reader partner (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Xorshift step; a fixed seed keeps every run the same
  function automatic logic [31:0] nx(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Frame start, n bits, end (eom or sync loss), then four stray bits to be ignored
  task automatic frame(input int n, input logic sl);
    logic op;
    rnd = nx(rnd);
    pattern_b_matched = rnd[2];
    frame_start_pattern = 1'b1;
    if (packet_fifo_mode && (ovf || (init_at_frame_start && !lk))) q.delete();
    ovf = ovf && !packet_fifo_mode;
    op = packet_fifo_mode && !lk;
    if (op && ext_start_mode) q.push_back(pattern_b_matched);
    @(negedge ref_clk);
    frame_start_pattern = 1'b0;
    for (int i = 0; i < n + 4; i++) begin
      if (i == n) begin
        sync_lost = sl;
        end_of_message = !sl;
        if (!sl && lock_enable_bit) lk = 1'b1;
        op = 1'b0;
        @(negedge ref_clk);
        sync_lost = 1'b0;
        end_of_message = 1'b0;
      end
      rnd = nx(rnd);
      data_bit = rnd[0];
      data_clk = 1'b1;
      if (op && q.size() == 256) ovf = 1'b1;
      else if (op) q.push_back(rnd[0]);
      @(negedge ref_clk);
      data_clk = 1'b0;
      @(negedge ref_clk);
    end
  endtask
  // One read transfer; the expected bits come off the front of the model queue
  task automatic rd();
    int k;
    int w;
    logic [31:0] ed;
    logic [31:0] msk;
    k = (q.size() > 32) ? 32 : q.size();
    ed = 32'h0;
    for (int i = 0; i < k; i++) ed[i] = q.pop_front();
    msk = (k == 32) ? 32'hffffffff : (32'h1 << k) - 32'h1;
    rnd = nx(rnd);
    slow = rnd[1];
    rd_start = 1'b1;
    @(negedge ref_clk);
    rd_start = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 3000) begin
      @(negedge ref_clk);
      w++;
    end
    chk(w < 3000, 1'b1);
    if (!ovf) begin
      chk(ndata, k);
      chk(data & msk, ed);
      chk(stat[5:0], k);
    end
    chk(stat[7], ovf);
    if (k > 0 && q.size() == 0) lk = 1'b0;
    @(negedge ref_clk);
    chk(locked, lk);
  endtask
  task automatic cyc(input int k);
    enter_host_run = (k == 0);
    poll_to_run = (k == 1);
    if (init_at_cycle_start) q.delete();
    if (init_at_cycle_start) lk = 1'b0;
    @(negedge ref_clk);
    enter_host_run = 1'b0;
    poll_to_run = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, well beyond the roughly 3000 cycles the tests need
  initial begin
    #600000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {packet_fifo_mode, lock_enable_bit, init_at_cycle_start, init_at_frame_start} = 4'h0;
    {ext_start_mode, frame_start_pattern, pattern_b_matched, end_of_message} = 4'h0;
    {sync_lost, enter_host_run, poll_to_run, data_clk, data_bit, rd_start} = 6'h0;
    {slow, lk, ovf} = 3'h0;
    rnd = 32'h40;
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    chk({locked, rx_chain_freeze, overflow_flag, writing}, 32'h0);
    packet_fifo_mode = 1'b1;
    frame(40, 1'b0);
    rd();
    rd();
    $display("test 1 done");
    ext_start_mode = 1'b1;
    frame(5, 1'b1);
    rd();
    ext_start_mode = 1'b0;
    packet_fifo_mode = 1'b0;
    frame(8, 1'b0);
    rd();
    packet_fifo_mode = 1'b1;
    $display("test 2 done");
    lock_enable_bit = 1'b1;
    init_at_frame_start = 1'b1;
    frame(10, 1'b0);
    chk({locked, rx_chain_freeze}, 32'h3);
    frame(10, 1'b0);
    rd();
    frame(6, 1'b0);
    lock_enable_bit = 1'b0;
    lk = 1'b0;
    @(negedge ref_clk);
    chk(locked, lk);
    rd();
    $display("test 3 done");
    lock_enable_bit = 1'b1;
    init_at_cycle_start = 1'b1;
    for (int k = 0; k < 2; k++) begin
      frame(7, 1'b0);
      cyc(k);
      chk(locked, lk);
      rd();
    end
    {lock_enable_bit, init_at_cycle_start} = 2'h0;
    frame(9, 1'b0);
    frame(4, 1'b0);
    rd();
    init_at_frame_start = 1'b0;
    $display("test 4 done");
    frame(200, 1'b0);
    while (q.size() > 0) rd();
    frame(100, 1'b1);
    while (q.size() > 0) rd();
    $display("test 5 done");
    frame(260, 1'b0);
    chk(overflow_flag, 1'b1);
    rd();
    frame(3, 1'b0);
    chk(overflow_flag, 1'b0);
    rd();
    chk(writing, 1'b0);
    $display("test 6 done");
    tally_and_finish();
  end
endmodule
